// *** shared/lpc_pkg.sv ***
// Constants and types shared by the low-power entry control block.
package lpc_pkg;
  localparam int LPC_ADDR_W = 12;
  localparam logic [11:0] LPC_CTRL_OFFSET = 12'h000;
  localparam int LPC_WORD_LSB = 2;
  localparam int LPC_PWE_BIT = 4;
  localparam int LPC_LOCK_BIT = 3;
  localparam int LPC_DSS_BIT = 2;
  localparam int LPC_SOHR_BIT = 1;
  localparam int LPC_RSVD_HI_LSB = 5;
  localparam int LPC_RSVD_LO_BIT = 0;
  localparam int LPC_PROT_NS_BIT = 1;
  localparam int LPC_STRB_LOW = 0;
  localparam int LPC_NUM_BANKS = 2;
  localparam logic LPC_BIT_RST = 1'h0;
  localparam logic [31:0] LPC_ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0] LPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] LPC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {LPC_RUN, LPC_WFE, LPC_SLEEP} lpc_state_t;
endpackage

// *** logic/lpc_event_latch.sv ***
// Event latch that remembers an event for the next wait-for-event.
`timescale 1ns/1ps
module lpc_event_latch
  import lpc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_set,
  input wire logic i_consume,
  output logic o_latched
);
  logic next_latched;

  // A new event in the consuming cycle survives, so no event is lost.
  assign next_latched = i_set | (o_latched & ~i_consume);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_latched <= LPC_BIT_RST;
    end else if (i_ce) begin
      o_latched <= next_latched;
    end
  end
endmodule

// *** logic/lpc_axil_slave.sv ***
// AXI4-Lite slave front end that turns bus traffic into register strobes.
`timescale 1ns/1ps
module lpc_axil_slave
  import lpc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [LPC_ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_wr_en,
  output logic [LPC_ADDR_W-1:0] o_wr_addr,
  output logic [2:0] o_wr_prot,
  output logic [31:0] o_wr_data,
  output logic [3:0] o_wr_strb,
  input wire logic i_wr_hit,
  output logic o_rd_en,
  input wire logic [31:0] i_rd_data,
  input wire logic i_rd_hit
);
  logic aw_hold;
  logic w_hold;
  wire aw_take = i_awvalid & o_awready;
  wire w_take = i_wvalid & o_wready;
  wire do_write = aw_hold & w_hold & ~o_bvalid;

  // Address and data are taken independently and held until both are present.
  assign o_awready = i_ce & ~aw_hold & ~o_bvalid;
  assign o_wready = i_ce & ~w_hold & ~o_bvalid;
  assign o_wr_en = i_ce & do_write;
  assign o_arready = i_ce & ~o_rvalid;
  assign o_rd_en = i_arvalid & o_arready;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_hold <= 1'h0;
      w_hold <= 1'h0;
      o_wr_addr <= '0;
      o_wr_prot <= 3'h0;
      o_wr_data <= LPC_ZERO_WORD;
      o_wr_strb <= 4'h0;
      o_bvalid <= 1'h0;
      o_bresp <= LPC_RESP_OKAY;
    end else if (i_ce) begin
      if (aw_take) begin
        aw_hold <= 1'h1;
        o_wr_addr <= i_awaddr;
        o_wr_prot <= i_awprot;
      end else if (do_write) begin
        aw_hold <= 1'h0;
      end
      if (w_take) begin
        w_hold <= 1'h1;
        o_wr_data <= i_wdata;
        o_wr_strb <= i_wstrb;
      end else if (do_write) begin
        w_hold <= 1'h0;
      end
      if (do_write) begin
        o_bvalid <= 1'h1;
        o_bresp <= i_wr_hit ? LPC_RESP_OKAY : LPC_RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'h0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rvalid <= 1'h0;
      o_rdata <= LPC_ZERO_WORD;
      o_rresp <= LPC_RESP_OKAY;
    end else if (i_ce) begin
      if (o_rd_en) begin
        o_rvalid <= 1'h1;
        o_rdata <= i_rd_data;
        o_rresp <= i_rd_hit ? LPC_RESP_OKAY : LPC_RESP_SLVERR;
      end else if (i_rready) begin
        o_rvalid <= 1'h0;
      end
    end
  end
endmodule

// *** logic/lpc_low_power_ctrl.sv ***
// Low-power entry control register with sleep state machine and event latch.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module lpc_low_power_ctrl
  import lpc_pkg::*;
#(
  parameter bit HAS_SECURITY = 1'b1
)
(
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_CE,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [LPC_ADDR_W-1:0] I_AWADDR,
  input wire logic [2:0] I_AWPROT,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [LPC_ADDR_W-1:0] I_ARADDR,
  input wire logic [2:0] I_ARPROT,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_CPU_NS,
  input wire logic I_WFE_EXEC,
  input wire logic I_SEV_EXEC,
  input wire logic I_EXT_EVENT,
  input wire logic I_IRQ_PEND,
  input wire logic I_IRQ_EN,
  input wire logic I_HANDLER_RETURN,
  output logic O_LOW_POWER,
  output logic O_DEEP_SLEEP,
  output logic O_WFE_HALT,
  output logic O_EVENT_LATCHED
);
  // Without the security option every access and the core use bank 0.
  function automatic logic lpc_bank(input logic ns);
    lpc_bank = HAS_SECURITY & ns;
  endfunction

  function automatic logic lpc_hit(input logic [LPC_ADDR_W-1:0] addr);
    lpc_hit = addr[LPC_ADDR_W-1:LPC_WORD_LSB] == LPC_CTRL_OFFSET[LPC_ADDR_W-1:LPC_WORD_LSB];
  endfunction

  logic wr_en;
  logic [LPC_ADDR_W-1:0] wr_addr;
  logic [2:0] wr_prot;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_en;
  logic [LPC_NUM_BANKS-1:0] pending_wake_enable;
  logic [LPC_NUM_BANKS-1:0] sleep_on_handler_return;
  logic deep_sleep_select;
  logic deep_sleep_secure_lock;
  logic event_latched;
  lpc_state_t state;
  lpc_state_t next_state;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;

  lpc_axil_slave u_bus (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_ce(I_CE),
    .i_awvalid(I_AWVALID),
    .o_awready(O_AWREADY),
    .i_awaddr(I_AWADDR),
    .i_awprot(I_AWPROT),
    .i_wvalid(I_WVALID),
    .o_wready(O_WREADY),
    .i_wdata(I_WDATA),
    .i_wstrb(I_WSTRB),
    .o_bvalid(O_BVALID),
    .i_bready(I_BREADY),
    .o_bresp(O_BRESP),
    .i_arvalid(I_ARVALID),
    .o_arready(O_ARREADY),
    .o_rvalid(O_RVALID),
    .i_rready(I_RREADY),
    .o_rdata(O_RDATA),
    .o_rresp(O_RRESP),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_prot(wr_prot),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .i_wr_hit(wr_hit),
    .o_rd_en(rd_en),
    .i_rd_data(rd_word),
    .i_rd_hit(rd_hit)
  );

  // Register access decode.
  assign wr_hit = lpc_hit(wr_addr);
  assign rd_hit = lpc_hit(I_ARADDR);
  wire wr_go = wr_en & wr_hit & wr_strb[LPC_STRB_LOW];
  wire wr_bank = lpc_bank(wr_prot[LPC_PROT_NS_BIT]);
  wire rd_bank = lpc_bank(I_ARPROT[LPC_PROT_NS_BIT]);
  wire cpu_bank = lpc_bank(I_CPU_NS);
  wire wr_ns_go = wr_go & wr_bank;

  wire dss_wr_ok = ~wr_bank | ~deep_sleep_secure_lock;
  wire dss_rd_ok = ~rd_bank | ~deep_sleep_secure_lock;
  wire lock_wr_ok = HAS_SECURITY & ~wr_bank;
  wire lock_rd_ok = HAS_SECURITY & ~rd_bank;

  wire [31:0] rd_fields = {{(31 - LPC_PWE_BIT){1'b0}},
                           pending_wake_enable[rd_bank],
                           deep_sleep_secure_lock & lock_rd_ok,
                           deep_sleep_select & dss_rd_ok,
                           sleep_on_handler_return[rd_bank],
                           1'b0};
  assign rd_word = rd_hit ? rd_fields : LPC_ZERO_WORD;

  genvar b;
  generate
    for (b = 0; b < LPC_NUM_BANKS; b++) begin : g_bank
      wire bank_wr = wr_go & (wr_bank == 1'(b));
      always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
          pending_wake_enable[b] <= LPC_BIT_RST;
          sleep_on_handler_return[b] <= LPC_BIT_RST;
        end else if (I_CE && bank_wr) begin
          pending_wake_enable[b] <= wr_data[LPC_PWE_BIT];
          sleep_on_handler_return[b] <= wr_data[LPC_SOHR_BIT];
        end
      end
    end
  endgenerate

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      deep_sleep_select <= LPC_BIT_RST;
      deep_sleep_secure_lock <= LPC_BIT_RST;
    end else if (I_CE && wr_go) begin
      if (dss_wr_ok) begin
        deep_sleep_select <= wr_data[LPC_DSS_BIT];
      end
      if (lock_wr_ok) begin
        deep_sleep_secure_lock <= wr_data[LPC_LOCK_BIT];
      end
    end
  end

  wire pwe_cur = pending_wake_enable[cpu_bank];
  wire sohr_cur = sleep_on_handler_return[cpu_bank];

  wire wake_event = I_SEV_EXEC | I_EXT_EVENT | (I_IRQ_PEND & pwe_cur);
  wire wake_any = wake_event | (I_IRQ_PEND & I_IRQ_EN);
  wire is_run = state == LPC_RUN;
  // A wait that finds an event already present does not halt at all.
  wire wfe_halt_go = is_run & I_WFE_EXEC & ~event_latched & ~wake_any;
  wire wfe_consume = is_run & I_WFE_EXEC & event_latched;
  wire latch_set = wake_event & (state != LPC_WFE) & ~(is_run & I_WFE_EXEC & ~event_latched);

  lpc_event_latch u_latch (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_ce(I_CE),
    .i_set(latch_set),
    .i_consume(wfe_consume),
    .o_latched(event_latched)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      LPC_RUN: begin
        if (wfe_halt_go) begin
          next_state = LPC_WFE;
        end else if (I_HANDLER_RETURN && sohr_cur) begin
          next_state = LPC_SLEEP;
        end
      end
      LPC_WFE: begin
        if (wake_any) begin
          next_state = LPC_RUN;
        end
      end
      LPC_SLEEP: begin
        if (wake_any) begin
          next_state = LPC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state <= LPC_RUN;
      O_LOW_POWER <= 1'h0;
      O_DEEP_SLEEP <= 1'h0;
      O_WFE_HALT <= 1'h0;
    end else if (I_CE) begin
      state <= next_state;
      O_LOW_POWER <= next_state != LPC_RUN;
      O_DEEP_SLEEP <= (next_state != LPC_RUN) & deep_sleep_select;
      O_WFE_HALT <= next_state == LPC_WFE;
    end
  end

  assign O_EVENT_LATCHED = event_latched;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);

  sequence s_ret_sleep;
    I_CE && is_run && I_HANDLER_RETURN && !wfe_halt_go;
  endsequence

  sequence s_wfe_halted;
    (I_CE && wfe_halt_go) ##1 (state == LPC_WFE);
  endsequence

  sequence s_ns_write;
    I_CE && wr_ns_go;
  endsequence

  sequence s_wfe_entry;
    I_CE && wfe_halt_go;
  endsequence

  sequence s_latch_kept;
    I_CE && event_latched && !wfe_consume;
  endsequence

  sequence s_sec_write;
    I_CE && wr_go && !wr_bank;
  endsequence

  deep_mode_a: assert property (I_CE && next_state != LPC_RUN |=> O_DEEP_SLEEP == $past(deep_sleep_select))
    else $error("deep sleep output does not follow the select bit");
  sleep_return_a: assert property (s_ret_sleep ##0 sohr_cur |=> state == LPC_SLEEP && O_LOW_POWER)
    else $error("no sleep on handler return with bit set");
  no_sleep_a: assert property (s_ret_sleep ##0 !sohr_cur |=> state != LPC_SLEEP)
    else $error("sleep on handler return with bit clear");
  disabled_irq_a: assert property (I_CE && state == LPC_SLEEP && !pwe_cur && !I_SEV_EXEC && !I_EXT_EVENT
                                   && !I_IRQ_EN |=> state == LPC_SLEEP)
    else $error("disabled interrupt woke the core");
  pend_wake_a: assert property (I_CE && !is_run && pwe_cur && I_IRQ_PEND |=> state == LPC_RUN && !O_LOW_POWER)
    else $error("pending interrupt did not wake with pending wake set");
  event_latch_a: assert property (I_CE && state == LPC_SLEEP && wake_event |=> event_latched)
    else $error("event outside a wait was not latched");
  latch_skip_a: assert property (I_CE && wfe_consume && !wake_event |=> is_run && !event_latched)
    else $error("latched event did not satisfy the next wait");
  wfe_wake_a: assert property (s_wfe_halted ##0 (I_CE && (I_SEV_EXEC || I_EXT_EVENT)) |=> state == LPC_RUN)
    else $error("send event or external event did not end the wait");
  pend_event_a: assert property (s_wfe_halted ##0 (I_CE && I_IRQ_PEND && pwe_cur) |=> !O_WFE_HALT)
    else $error("pending interrupt event did not end the wait");
  lock_read_a: assert property (rd_en && rd_bank && deep_sleep_secure_lock |=> O_RDATA[LPC_DSS_BIT] == 1'b0)
    else $error("locked select visible to non-secure read");
  lock_write_a: assert property (s_ns_write ##0 deep_sleep_secure_lock |=> $stable(deep_sleep_select))
    else $error("locked select changed by non-secure write");
  lock_ns_a: assert property (s_ns_write |=> $stable(deep_sleep_secure_lock))
    else $error("lock bit changed by non-secure write");
  banked_a: assert property (s_ns_write |=> $stable(pending_wake_enable[0]) && $stable(sleep_on_handler_return[0]))
    else $error("non-secure write changed the secure bank");
  reserved_a: assert property (O_RVALID |-> O_RDATA[31:LPC_RSVD_HI_LSB] == '0
                               && O_RDATA[LPC_RSVD_LO_BIT] == 1'b0)
    else $error("reserved read data not zero");

  wfe_enter_a: assert property (s_wfe_entry |=> O_WFE_HALT && O_LOW_POWER)
    else $error("wait without a latched event did not halt");
  light_mode_a: assert property (I_CE && next_state != LPC_RUN && !deep_sleep_select |=> !O_DEEP_SLEEP)
    else $error("deep sleep shown with the select bit clear");
  run_awake_a: assert property (I_CE && next_state == LPC_RUN |=> !O_LOW_POWER
                                && !O_DEEP_SLEEP && !O_WFE_HALT)
    else $error("low-power outputs high while running");
  wfe_irq_off_a: assert property (I_CE && state == LPC_WFE && !pwe_cur && !I_IRQ_EN && !I_SEV_EXEC
                                  && !I_EXT_EVENT |=> state == LPC_WFE)
    else $error("disabled interrupt ended the wait");
  sleep_event_a: assert property (I_CE && state == LPC_SLEEP && (I_SEV_EXEC || I_EXT_EVENT) |=> is_run)
    else $error("event did not end the sleep");
  wake_clear_a: assert property (I_CE && !is_run && wake_any |=> is_run && !O_LOW_POWER)
    else $error("wake source left the core in low power");
  wfe_no_latch_a: assert property (I_CE && state == LPC_WFE |=> !event_latched)
    else $error("event latched while the wait was in progress");
  wfe_same_a: assert property (I_CE && is_run && I_WFE_EXEC && wake_any && !event_latched
                               |=> !O_WFE_HALT && !event_latched)
    else $error("wait with a wake source present halted or latched");
  latch_hold_a: assert property (s_latch_kept |=> event_latched)
    else $error("latched event lost before a wait used it");
  latch_race_a: assert property (I_CE && wfe_consume && wake_event |=> event_latched)
    else $error("event in the consuming cycle was lost");
  sel_write_a: assert property (I_CE && wr_go && dss_wr_ok |=>
                                deep_sleep_select == $past(wr_data[LPC_DSS_BIT]))
    else $error("permitted write did not reach the select bit");
  lock_sec_a: assert property (s_sec_write |=>
                               deep_sleep_secure_lock == ($past(wr_data[LPC_LOCK_BIT]) && HAS_SECURITY))
    else $error("secure write did not reach the lock bit");
  bank_ns_a: assert property (s_ns_write |=> pending_wake_enable[1] == $past(wr_data[LPC_PWE_BIT])
                              && sleep_on_handler_return[1] == $past(wr_data[LPC_SOHR_BIT]))
    else $error("non-secure write did not reach the non-secure bank");
  bank_sec_a: assert property (s_sec_write |=> $stable(pending_wake_enable[1])
                               && $stable(sleep_on_handler_return[1]))
    else $error("secure write changed the non-secure bank");
  unmapped_wr_a: assert property (I_CE && wr_en && !wr_hit |=> $stable(deep_sleep_select)
                                  && $stable(deep_sleep_secure_lock) && $stable(pending_wake_enable)
                                  && $stable(sleep_on_handler_return))
    else $error("write outside the register changed it");
  unmapped_rd_a: assert property (rd_en && !rd_hit |=> O_RDATA == LPC_ZERO_WORD)
    else $error("read outside the register returned data");
  // Reads compare with the sampled state, since a write may land on the edge that takes the read.
  lock_view_a: assert property (rd_en && rd_hit && !rd_bank |=>
                                O_RDATA[LPC_LOCK_BIT] == ($past(deep_sleep_secure_lock) && HAS_SECURITY))
    else $error("secure read did not show the lock bit");
  lock_hide_a: assert property (rd_en && rd_bank |=> O_RDATA[LPC_LOCK_BIT] == 1'b0)
    else $error("lock bit visible to non-secure read");
  bank_view_a: assert property (rd_en && rd_hit |=>
                                O_RDATA[LPC_PWE_BIT] == $past(pending_wake_enable[rd_bank]))
    else $error("read did not show the banked pending-wake bit");
endmodule

// *** bench/tb_low_power_entry_control.sv ***
// Self-checking bench for the low-power entry control register and its sleep logic.
`timescale 1ns/1ps
module tb_low_power_entry_control;
  import lpc_pkg::*;
  localparam logic [5:0] WF = 6'h10, SE = 6'h08, EX = 6'h04, IR = 6'h02, HR = 6'h01, EN = 6'h20;
  logic clk = 0, rstn = 0, ce = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, cpu_ns = 0, irq_en = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [2:0] awp = 0, arp = 0;
  logic [31:0] wd = 0, r;
  logic [3:0] ws = 0;
  logic [4:0] cv = 0;
  logic awr, wrd, bv, arr, rv, lp, ds, wh, el;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [35:0] q[$];
  logic [1:0] pwe = 0, soh = 0;
  logic lock = 0, dss = 0;
  int fails = 0, check_count = 0;
  event ev_stat;

  always #12.5 clk = ~clk;

  lpc_low_power_ctrl #(.HAS_SECURITY(1'b1)) dut (
    .I_CLK(clk), .I_RESETN(rstn), .I_CE(ce), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
    .I_AWPROT(awp), .I_WVALID(wv), .O_WREADY(wrd), .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bv),
    .I_BREADY(br), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .I_ARPROT(arp),
    .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rdata), .O_RRESP(rresp), .I_CPU_NS(cpu_ns),
    .I_WFE_EXEC(cv[4]), .I_SEV_EXEC(cv[3]), .I_EXT_EVENT(cv[2]), .I_IRQ_PEND(cv[1]), .I_IRQ_EN(irq_en),
    .I_HANDLER_RETURN(cv[0]), .O_LOW_POWER(lp), .O_DEEP_SLEEP(ds), .O_WFE_HALT(wh), .O_EVENT_LATCHED(el));

  // Reference copy of the register; the select uses the lock value from before the write.
  task automatic apply(input logic ns, input logic [31:0] d, input logic [3:0] s);
    if (s[0]) begin
      pwe[ns] = d[4];
      soh[ns] = d[1];
      if (!ns || !lock) dss = d[2];
      if (!ns) lock = d[3];
    end
  endtask

  function automatic logic [31:0] rval(input logic ns);
    rval = {27'h0, pwe[ns], lock & !ns, dss & !(ns & lock), soh[ns], 1'b0};
  endfunction

  task automatic cmp(input logic [35:0] g, input logic [35:0] x);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic wr(input logic ns, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic at, wt, atn, wtn;
    at = 0;
    wt = 0;
    q.push_back({2'h1, (a == LPC_CTRL_OFFSET) ? LPC_RESP_OKAY : LPC_RESP_SLVERR, 32'h0});
    if (a == LPC_CTRL_OFFSET) apply(ns, d, s);
    @(posedge clk);
    awv <= 1;
    wv <= 1;
    br <= 1;
    awa <= a;
    awp <= {1'b0, ns, 1'b0};
    wd <= d;
    ws <= s;
    while (!(at && wt)) begin
      @(negedge clk);
      atn = !at && awr;
      wtn = !wt && wrd;
      @(posedge clk);
      if (atn) awv <= 0;
      if (wtn) wv <= 0;
      at = at || atn;
      wt = wt || wtn;
    end
    do @(negedge clk); while (!bv);
    @(posedge clk);
    br <= 0;
  endtask

  task automatic rd(input logic ns, input logic [11:0] a);
    logic hit;
    hit = a == LPC_CTRL_OFFSET;
    q.push_back({2'h0, hit ? LPC_RESP_OKAY : LPC_RESP_SLVERR, hit ? rval(ns) : LPC_ZERO_WORD});
    @(posedge clk);
    arv <= 1;
    rr <= 1;
    ara <= a;
    arp <= {1'b0, ns, 1'b0};
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 0;
    do @(negedge clk); while (!rv);
    @(posedge clk);
    rr <= 0;
  endtask

  // Bit 5 of the pulse word is the enable level of the interrupt, which stays after the pulse.
  task automatic pulse(input logic [5:0] v);
    @(posedge clk);
    cv <= v[4:0];
    irq_en <= v[5];
    @(posedge clk);
    cv <= 5'h0;
  endtask

  task automatic chk(input logic l, input logic w, input logic v);
    @(negedge clk);
    q.push_back({2'h2, 2'h0, 28'h0, l, l & dss, w, v});
    -> ev_stat;
  endtask

  always @(negedge clk) begin
    if ((bv && br) || (rv && rr)) cmp((bv && br) ? {2'h1, bresp, 32'h0} : {2'h0, rresp, rdata}, q.pop_front());
  end

  always @(ev_stat) begin
    cmp({2'h2, 2'h0, 28'h0, lp, ds, wh, el}, q.pop_front());
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // The tests need a few hundred cycles; this limit leaves wide margin.
  initial begin
    #500000;
    fails++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    r = $urandom(32'h8912);
    repeat (10) @(posedge clk);
    rstn <= 1;
    rd(0, LPC_CTRL_OFFSET);
    rd(1, LPC_CTRL_OFFSET);
    wr(0, LPC_CTRL_OFFSET, 32'hFFFF_FFFF, 4'hF);
    rd(0, LPC_CTRL_OFFSET);
    rd(1, LPC_CTRL_OFFSET);
    wr(1, LPC_CTRL_OFFSET, 32'hFFFF_FFFF, 4'hF);
    rd(1, LPC_CTRL_OFFSET);
    rd(0, LPC_CTRL_OFFSET);
    wr(0, LPC_CTRL_OFFSET, 32'h0000_0004, 4'hF);
    wr(1, LPC_CTRL_OFFSET, 32'h0000_000A, 4'hF);
    rd(1, LPC_CTRL_OFFSET);
    rd(0, LPC_CTRL_OFFSET);
    wr(0, 12'h004, 32'h0000_001E, 4'hF);
    rd(0, 12'h004);
    wr(0, LPC_CTRL_OFFSET, 32'h0000_001E, 4'h0);
    rd(0, LPC_CTRL_OFFSET);
    $display("Test register access done");
    repeat (12) begin
      r = $urandom;
      wr(r[0], LPC_CTRL_OFFSET, $urandom, r[7:4]);
      rd(r[1], LPC_CTRL_OFFSET);
    end
    $display("Test random access done");
    wr(0, LPC_CTRL_OFFSET, 32'h0, 4'h1);
    wr(1, LPC_CTRL_OFFSET, 32'h0, 4'h1);
    pulse(WF);
    chk(1, 1, 0);
    pulse(SE);
    chk(0, 0, 0);
    pulse(WF);
    pulse(EX);
    chk(0, 0, 0);
    pulse(SE);
    chk(0, 0, 1);
    pulse(WF);
    chk(0, 0, 0);
    pulse(WF);
    pulse(IR);
    chk(1, 1, 0);
    pulse(EN | IR);
    chk(0, 0, 0);
    wr(0, LPC_CTRL_OFFSET, 32'h0000_0010, 4'h1);
    pulse(WF);
    pulse(IR);
    chk(0, 0, 0);
    pulse(IR);
    chk(0, 0, 1);
    pulse(WF);
    chk(0, 0, 0);
    @(posedge clk);
    ce <= 0;
    pulse(SE);
    chk(0, 0, 0);
    @(posedge clk);
    ce <= 1;
    $display("Test wait and wake done");
    for (int k = 0; k < 2; k++) begin
      wr(0, LPC_CTRL_OFFSET, {27'h0, 1'b1, 1'b0, k[0], 1'b0, 1'b0}, 4'h1);
      pulse(HR);
      chk(0, 0, 0);
      wr(0, LPC_CTRL_OFFSET, {27'h0, 1'b1, 1'b0, k[0], 1'b1, 1'b0}, 4'h1);
      pulse(HR);
      chk(1, 0, 0);
      pulse(SE);
      chk(0, 0, 1);
      pulse(WF);
      chk(0, 0, 0);
    end
    $display("Test sleep on return done");
    @(posedge clk);
    cpu_ns <= 1;
    pulse(HR);
    chk(0, 0, 0);
    wr(1, LPC_CTRL_OFFSET, 32'h0000_0002, 4'h1);
    pulse(HR);
    chk(1, 0, 0);
    pulse(IR);
    chk(1, 0, 0);
    pulse(EN | IR);
    chk(0, 0, 0);
    $display("Test core bank done");
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule
